// ==== hdl/data_eeprom_access_ctrl.sv ====
// Data EEPROM access controller: SPECIAL_FUNCTION_REGISTER port, unlock sequence, read and timed write.
// Assumes the core issues at most one SPECIAL_FUNCTION_REGISTER access per clock and drives warmRst for
// external, watchdog and brownout resets; srst is the power-on reset.
//
// Behaviour
// RULE1 EEPROM cells are reached only through the four SFRs, never mapped directly.
// RULE2 Data byte register is eight bits, holds write value or read result.
// RULE3 Small variant holds 128 bytes using location index bits 6 to 0.
// RULE4 Large variant holds 256 bytes, locations zero to 0xFF.
// RULE5 Large variant decodes all eight index bits; top bit picks upper half.
// RULE6 Software keeps index top bit zero on the small variant.
// RULE7 Each byte write erases the location before programming the new value.
// RULE8 An internal timer decides when the write cycle ends.
// RULE9 Code protection keeps CPU access but blocks external programmer access.
// RULE10 Control bits 7 to 4 are absent and read zero.
// RULE11 Read and write triggers set by writing one, cleared by hardware.
// RULE12 Write allowed only with write permit set; permit clear after power-up.
// RULE13 Abort flag set when external, watchdog or brownout reset cuts a write.
// RULE14 Abort flag reads zero after a write completes normally.
// RULE15 Data and index registers keep their values across an aborting reset.
// RULE16 Write-done flag set on completion, cleared only by software.
// RULE17 Unlock port has no storage and reads zero.
// RULE18 Data, index and abort flag have undefined power-on contents.
// RULE19 Read result lands in data register by the next instruction cycle.
// RULE20 Write starts only after exact 0x55, 0xAA, trigger sequence with timing.
// RULE21 Write trigger set attempts ignored while write permit is clear.
// RULE22 Clearing write permit mid-write does not disturb the write.
// RULE23 Write trigger stays set and new starts ignored until timer ends.
`timescale 1ns/100ps
module data_eeprom_access_ctrl
  import eeprom_ctrl_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic warmRst,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWe,
  input wire logic sfrRe,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  input wire logic writeDoneClr,
  output logic writeDoneFlag,
  input wire logic codeProtect,
  output logic progAccessOk
);
  // ----------------------------------------------------------------
  // Decode and state
  // ----------------------------------------------------------------
  typedef enum {KEY_IDLE, KEY_GOT_FIRST, KEY_GOT_SECOND} key_state_e;

  ee_mem_if memIf ();
  key_state_e keyState_ff;
  logic [1:0] keyCnt_ff;
  logic [7:0] dataByte_ff;
  logic [7:0] location_ff;
  logic [7:0] wrLocation_ff;
  logic readTrig_ff;
  logic writeBusy_ff;
  logic writePermit_ff;
  logic abortFlag_ff;
  logic eraseNow_ff;
  logic timerDone;
  logic wrData, wrLoc, wrCtrl, wrKey;
  logic unlockOk, startWrite, setRead, keyOnTime;
  logic [7:0] effLocation;

  assign wrData = sfrWe && (sfrAddr == ADDR_DATA_BYTE);
  assign wrLoc = sfrWe && (sfrAddr == ADDR_LOCATION);
  assign wrCtrl = sfrWe && (sfrAddr == ADDR_CONTROL);
  assign wrKey = sfrWe && (sfrAddr == ADDR_UNLOCK_KEY);
  assign keyOnTime = (keyCnt_ff == KEY_GAP - 2'h1);
  assign unlockOk = (keyState_ff == KEY_GOT_SECOND) && keyOnTime; // RULE20
  assign startWrite = wrCtrl && sfrWdata[BIT_WRITE_TRIG] && unlockOk && writePermit_ff
                      && !writeBusy_ff && !warmRst; // RULE20 RULE21 RULE23 RULE12
  assign setRead = wrCtrl && sfrWdata[BIT_READ_TRIG] && !writeBusy_ff && !warmRst; // RULE11
  // Small variant ignores the top index bit; software keeps it at zero
  assign effLocation = LARGE_VARIANT ? location_ff : {1'b0, location_ff[6:0]}; // RULE3 RULE4 RULE5 RULE6

  // ----------------------------------------------------------------
  // Unlock sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || warmRst) begin
      keyState_ff <= KEY_IDLE;
      keyCnt_ff <= 2'h0;
    end else if (wrKey && sfrWdata == KEY_FIRST && !(keyState_ff == KEY_GOT_FIRST && keyOnTime)) begin
      keyState_ff <= KEY_GOT_FIRST;
      keyCnt_ff <= 2'h0;
    end else begin
      keyCnt_ff <= keyCnt_ff + 2'h1;
      case (keyState_ff)
        KEY_IDLE: begin
          keyCnt_ff <= 2'h0;
        end
        KEY_GOT_FIRST: begin
          if (keyOnTime && wrKey && sfrWdata == KEY_SECOND) begin
            keyState_ff <= KEY_GOT_SECOND; // RULE20
            keyCnt_ff <= 2'h0;
          end else if (keyOnTime || sfrWe) begin
            keyState_ff <= KEY_IDLE;
          end
        end
        KEY_GOT_SECOND: begin
          if (keyOnTime || sfrWe) begin
            keyState_ff <= KEY_IDLE; // RULE20
          end
        end
        default: begin
          keyState_ff <= KEY_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Data byte and location index
  // ----------------------------------------------------------------
  // Warm reset leaves both untouched so software can retry the write
  always_ff @(posedge clk) begin
    if (srst) begin
      dataByte_ff <= BYTE_RESET; // RULE18
    end else if (readTrig_ff) begin
      dataByte_ff <= memIf.rdata; // RULE19
    end else if (wrData) begin
      dataByte_ff <= sfrWdata; // RULE2 RULE15
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      location_ff <= BYTE_RESET; // RULE18
    end else if (wrLoc) begin
      location_ff <= sfrWdata; // RULE15
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || warmRst) begin
      readTrig_ff <= 1'b0;
    end else begin
      readTrig_ff <= setRead; // RULE11 RULE19
    end
  end

  always_ff @(posedge clk) begin
    if (srst || warmRst) begin
      writePermit_ff <= CTRL_RESET[BIT_WRITE_PERMIT]; // RULE12
    end else if (wrCtrl) begin
      writePermit_ff <= sfrWdata[BIT_WRITE_PERMIT]; // RULE22
    end
  end

  always_ff @(posedge clk) begin
    if (srst || warmRst) begin
      writeBusy_ff <= 1'b0;
    end else if (startWrite) begin
      writeBusy_ff <= 1'b1; // RULE11
    end else if (timerDone) begin
      writeBusy_ff <= 1'b0; // RULE8 RULE23
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      abortFlag_ff <= CTRL_RESET[BIT_WRITE_ABORT]; // RULE18
    end else if (warmRst && writeBusy_ff) begin
      abortFlag_ff <= 1'b1; // RULE13
    end else if (writeBusy_ff && timerDone) begin
      abortFlag_ff <= 1'b0; // RULE14
    end else if (wrCtrl) begin
      abortFlag_ff <= sfrWdata[BIT_WRITE_ABORT];
    end
  end

  // Set wins over the software clear
  always_ff @(posedge clk) begin
    if (srst) begin
      writeDoneFlag <= 1'b0;
    end else if (writeBusy_ff && timerDone && !warmRst) begin
      writeDoneFlag <= 1'b1; // RULE16
    end else if (writeDoneClr) begin
      writeDoneFlag <= 1'b0; // RULE16
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      progAccessOk <= 1'b0;
    end else begin
      progAccessOk <= !codeProtect; // RULE9
    end
  end

  // ----------------------------------------------------------------
  // Write cycle: erase at start, program at timer end
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      wrLocation_ff <= BYTE_RESET;
      eraseNow_ff <= 1'b0;
    end else begin
      eraseNow_ff <= startWrite;
      if (startWrite) begin
        wrLocation_ff <= effLocation;
      end
    end
  end

  assign memIf.addr = writeBusy_ff ? wrLocation_ff : effLocation; // RULE1
  assign memIf.we = writeBusy_ff && !warmRst && (eraseNow_ff || timerDone); // RULE7
  assign memIf.wdata = eraseNow_ff ? ERASED_BYTE : dataByte_ff; // RULE7

  ee_byte_array u_array (
    .clk(clk),
    .memPort(memIf.mem)
  );

  ee_write_timer #(
    .CYCLES(WRITE_CYCLES)
  ) u_timer (
    .clk(clk),
    .srst(srst),
    .start(startWrite),
    .cancel(warmRst),
    .done(timerDone) // RULE8
  );

  // ----------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      sfrRdata <= BYTE_RESET;
    end else if (sfrRe) begin
      case (sfrAddr)
        ADDR_DATA_BYTE: sfrRdata <= dataByte_ff;
        ADDR_LOCATION: sfrRdata <= location_ff;
        ADDR_CONTROL: sfrRdata <= {4'h0, abortFlag_ff, writePermit_ff, writeBusy_ff, readTrig_ff}; // RULE10
        default: sfrRdata <= BYTE_RESET; // RULE17
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_read_next;
    @(posedge clk) disable iff (srst)
    setRead |=> readTrig_ff ##1 (readTrig_ff == $past(setRead) && dataByte_ff == $past(memIf.rdata));
  endproperty
  a_read_next: assert property (p_read_next) else $error("read result not loaded next cycle"); // RULE19

  property p_ctrl_upper_zero;
    @(posedge clk) disable iff (srst)
    (sfrRe && sfrAddr == ADDR_CONTROL) |=> (sfrRdata[7:4] == 4'h0);
  endproperty
  a_ctrl_upper_zero: assert property (p_ctrl_upper_zero) else $error("control upper bits not zero"); // RULE10

  property p_key_reads_zero;
    @(posedge clk) disable iff (srst)
    (sfrRe && sfrAddr == ADDR_UNLOCK_KEY) |=> (sfrRdata == 8'h00);
  endproperty
  a_key_reads_zero: assert property (p_key_reads_zero) else $error("unlock port read not zero"); // RULE17

  property p_permit_blocks;
    @(posedge clk) disable iff (srst)
    (wrCtrl && sfrWdata[BIT_WRITE_TRIG] && !writePermit_ff && !writeBusy_ff) |=> !writeBusy_ff;
  endproperty
  a_permit_blocks: assert property (p_permit_blocks) else $error("write started without permit"); // RULE21

  property p_busy_holds;
    @(posedge clk) disable iff (srst)
    (writeBusy_ff && !warmRst && !timerDone) |=> writeBusy_ff;
  endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("write trigger dropped early"); // RULE23

  property p_done_sets;
    @(posedge clk) disable iff (srst)
    (writeBusy_ff && timerDone && !warmRst) |=> (writeDoneFlag && !abortFlag_ff && !writeBusy_ff);
  endproperty
  a_done_sets: assert property (p_done_sets) else $error("completion flags wrong"); // RULE16

  property p_abort_sets;
    @(posedge clk) disable iff (srst)
    (writeBusy_ff && warmRst) |=> (abortFlag_ff && !writeBusy_ff);
  endproperty
  a_abort_sets: assert property (p_abort_sets) else $error("aborted write not flagged"); // RULE13

  property p_keep_on_warm;
    @(posedge clk) disable iff (srst)
    (warmRst && !readTrig_ff && !wrData && !wrLoc) |=>
      (dataByte_ff == $past(dataByte_ff) && location_ff == $past(location_ff));
  endproperty
  a_keep_on_warm: assert property (p_keep_on_warm) else $error("data or index lost on warm reset"); // RULE15

  property p_start_needs_key;
    @(posedge clk) disable iff (srst)
    $rose(writeBusy_ff) |-> $past(unlockOk) ##1 (writeBusy_ff && !memIf.we);
  endproperty
  a_start_needs_key: assert property (p_start_needs_key) else $error("write started without unlock"); // RULE20

  property p_erase_first;
    @(posedge clk) disable iff (srst)
    ($rose(writeBusy_ff) && !warmRst) |->
      (memIf.we && memIf.wdata == ERASED_BYTE && memIf.addr == wrLocation_ff);
  endproperty
  a_erase_first: assert property (p_erase_first) else $error("write did not erase first"); // RULE7

  property p_warm_clears;
    @(posedge clk) disable iff (srst)
    warmRst |=> (!writePermit_ff && !readTrig_ff && !writeBusy_ff);
  endproperty
  a_warm_clears: assert property (p_warm_clears) else $error("warm reset left permit or trigger set"); // RULE12

  property p_prog_gate;
    @(posedge clk) disable iff (srst)
    codeProtect |=> !progAccessOk;
  endproperty
  a_prog_gate: assert property (p_prog_gate) else $error("programmer access open under protection"); // RULE9
endmodule : data_eeprom_access_ctrl

// ==== hdl/ee_byte_array.sv ====
// Byte array standing in for the EEPROM cells.
// Assumes the controller has already folded the address for the small variant.
`timescale 1ns/100ps
module ee_byte_array (
  input wire logic clk,
  ee_mem_if.mem memPort
);
  logic [7:0] cells [256];

  always_ff @(posedge clk) begin
    if (memPort.we) begin
      cells[memPort.addr] <= memPort.wdata;
    end
  end

  assign memPort.rdata = cells[memPort.addr];
endmodule : ee_byte_array

// ==== hdl/ee_mem_if.sv ====
// Port between the controller and the byte array.
// Assumes the array writes on the clock edge and reads combinationally.
`timescale 1ns/100ps
interface ee_mem_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic we;
  logic [7:0] rdata;
  modport ctrl (output addr, output wdata, output we, input rdata);
  modport mem (input addr, input wdata, input we, output rdata);
endinterface : ee_mem_if

// ==== hdl/ee_write_timer.sv ====
// Write cycle timer: a one-cycle done pulse CYCLES clocks after start.
// Assumes start is not raised while running; cancel stops it at once.
`timescale 1ns/100ps
module ee_write_timer #(
  parameter int CYCLES = 40000
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic cancel,
  output logic done
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] count_ff;
  logic running_ff;

  always_ff @(posedge clk) begin
    if (srst || cancel) begin
      running_ff <= 1'b0;
      count_ff <= '0;
    end else if (start) begin
      running_ff <= 1'b1;
      count_ff <= '0;
    end else if (running_ff) begin
      count_ff <= count_ff + 1'b1;
      if (count_ff == LAST) begin
        running_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst || cancel) begin
      done <= 1'b0;
    end else begin
      done <= running_ff && (count_ff == LAST);
    end
  end
endmodule : ee_write_timer

// ==== hdl/eeprom_ctrl_pkg.sv ====
// Constants for the data EEPROM access controller.
// Assumes a single 10 MHz core clock; bus accesses are one clock per instruction cycle.
package eeprom_ctrl_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA_BYTE = 8'h9a;
  localparam logic [7:0] ADDR_LOCATION = 8'h9b;
  localparam logic [7:0] ADDR_CONTROL = 8'h9c;
  localparam logic [7:0] ADDR_UNLOCK_KEY = 8'h9d;
  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int BIT_READ_TRIG = 0;
  localparam int BIT_WRITE_TRIG = 1;
  localparam int BIT_WRITE_PERMIT = 2;
  localparam int BIT_WRITE_ABORT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // ----------------------------------------------------------------
  // Unlock sequence
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [1:0] KEY_GAP = 2'h2;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int WRITE_TIME_NS = 4000000;
  localparam int WRITE_CYCLES_DEF = WRITE_TIME_NS / CLK_PERIOD_NS;
endpackage : eeprom_ctrl_pkg

// ==== verification/cpu_core_model.sv ====
// Core model issuing SPECIAL_FUNCTION_REGISTER accesses to the data EEPROM controller.
// Assumes callers start each task just after a rising clock edge.
`timescale 1ns/100ps
module cpu_core_model
  import eeprom_ctrl_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic clk,
  output logic [7:0] sfrAddr,
  output logic sfrWe,
  output logic sfrRe,
  output logic [7:0] sfrWdata,
  output logic writeDoneClr,
  input wire logic [7:0] sfrRdata
);
  initial begin
    sfrAddr = 8'h00;
    sfrWe = 1'b0;
    sfrRe = 1'b0;
    sfrWdata = 8'h00;
    writeDoneClr = 1'b0;
  end

  // One bus cycle: every line is set once, then held through the sampling edge
  task automatic drive(input logic we, input logic re, input logic [7:0] a, input logic [7:0] d, input logic clr);
    sfrWe = we;
    sfrRe = re;
    sfrAddr = a;
    sfrWdata = d;
    writeDoneClr = clr;
    @(posedge clk);
    #1;
  endtask : drive

  // Strobes drop low; address and data are inverted so a stale value never looks valid
  task automatic step();
    drive(1'b0, 1'b0, ~sfrAddr, ~sfrWdata, 1'b0);
  endtask : step

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    drive(1'b1, 1'b0, a, d, 1'b0);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    drive(1'b0, 1'b1, a, ~sfrWdata, 1'b0);
    step();
    d = sfrRdata;
  endtask : rd_reg

  task automatic set_index(input logic [7:0] a);
    wr_reg(ADDR_LOCATION, LARGE_VARIANT ? a : {1'b0, a[6:0]});
  endtask : set_index

  // Key writes spaced by gap clocks, then the control write
  task automatic unlock_write(input logic [7:0] ctrl, input int gap);
    wr_reg(ADDR_UNLOCK_KEY, KEY_FIRST);
    repeat (gap - 1) step();
    wr_reg(ADDR_UNLOCK_KEY, KEY_SECOND);
    repeat (gap - 1) step();
    wr_reg(ADDR_CONTROL, ctrl);
  endtask : unlock_write

  task automatic ee_read(input logic [7:0] a, input logic [7:0] ctrl, output logic [7:0] d);
    set_index(a);
    wr_reg(ADDR_CONTROL, ctrl | 8'h01);
    step();
    rd_reg(ADDR_DATA_BYTE, d);
  endtask : ee_read

  task automatic clear_done();
    drive(1'b0, 1'b0, ~sfrAddr, ~sfrWdata, 1'b1);
    step();
  endtask : clear_done
endmodule : cpu_core_model

// ==== verification/tb_top.sv ====
// Self-checking bench for the data EEPROM access controller.
// Assumes the core model in cpu_core_model.sv and a short write time.
`timescale 1ns/100ps
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
  $display("ERROR at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
  import eeprom_ctrl_pkg::*;
  localparam int WCYC = 20;
  logic clk, srst, warmRst, codeProtect, sfrWe, sfrRe, writeDoneClr, writeDoneFlag, progAccessOk;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata, got, a, d;
  logic sfrWeS, sfrReS, writeDoneClrS, writeDoneFlagS, progAccessOkS;
  logic [7:0] sfrAddrS, sfrWdataS, sfrRdataS;
  logic [7:0] expMem [256];
  int num_errors = 0;
  int samples_checked = 0;
  logic [7:0] corner [4] = '{8'h00, 8'hff, 8'h80, 8'h7f};

  data_eeprom_access_ctrl #(.LARGE_VARIANT(1'b1), .WRITE_CYCLES(WCYC)) DUT (.clk(clk), .srst(srst),
    .warmRst(warmRst), .sfrAddr(sfrAddr), .sfrWe(sfrWe), .sfrRe(sfrRe), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata), .writeDoneClr(writeDoneClr), .writeDoneFlag(writeDoneFlag),
    .codeProtect(codeProtect), .progAccessOk(progAccessOk));
  cpu_core_model #(.LARGE_VARIANT(1'b1)) cpu (.clk(clk), .sfrAddr(sfrAddr), .sfrWe(sfrWe),
    .sfrRe(sfrRe), .sfrWdata(sfrWdata), .writeDoneClr(writeDoneClr), .sfrRdata(sfrRdata));
  // Small variant, driven by its own core model
  data_eeprom_access_ctrl #(.LARGE_VARIANT(1'b0), .WRITE_CYCLES(WCYC)) DUT_SMALL (.clk(clk), .srst(srst),
    .warmRst(warmRst), .sfrAddr(sfrAddrS), .sfrWe(sfrWeS), .sfrRe(sfrReS), .sfrWdata(sfrWdataS),
    .sfrRdata(sfrRdataS), .writeDoneClr(writeDoneClrS), .writeDoneFlag(writeDoneFlagS),
    .codeProtect(codeProtect), .progAccessOk(progAccessOkS));
  cpu_core_model #(.LARGE_VARIANT(1'b0)) cpuSmall (.clk(clk), .sfrAddr(sfrAddrS), .sfrWe(sfrWeS),
    .sfrRe(sfrReS), .sfrWdata(sfrWdataS), .writeDoneClr(writeDoneClrS), .sfrRdata(sfrRdataS));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [7:0] ctrl_val(input logic abort, input logic permit, input logic wr);
    return {4'h0, abort, permit, wr, 1'b0};
  endfunction : ctrl_val

  task automatic test_done();
    $display("Checks made: %0d, mismatches: %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // Start a keyed write; reports whether the controller went busy
  task automatic start_write(input logic [7:0] ad, input logic [7:0] dt, input int gap);
    cpu.set_index(ad);
    cpu.wr_reg(ADDR_DATA_BYTE, dt);
    cpu.unlock_write(ctrl_val(1'b0, 1'b1, 1'b1), gap);
    cpu.rd_reg(ADDR_CONTROL, got);
    `CHECK(got, ctrl_val(1'b0, 1'b1, gap == int'(KEY_GAP)))
  endtask : start_write

  task automatic wait_done(input logic [7:0] ctrlExp);
    for (int i = 0; i < WCYC * 4 && writeDoneFlag !== 1'b1; i++) cpu.step();
    `CHECK(writeDoneFlag, 1'b1)
    cpu.rd_reg(ADDR_CONTROL, got);
    `CHECK(got, ctrlExp)
    `CHECK(writeDoneFlag, 1'b1)
    cpu.clear_done();
    `CHECK(writeDoneFlag, 1'b0)
  endtask : wait_done

  initial begin
    void'($urandom(32'h06e86bf4));
    srst = 1'b1;
    warmRst = 1'b0;
    codeProtect = 1'b0;
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    cpu.rd_reg(ADDR_CONTROL, got);
    `CHECK(got & 8'hf7, 8'h00)
    cpu.rd_reg(ADDR_UNLOCK_KEY, got);
    `CHECK(got, 8'h00)
    cpu.rd_reg(8'h9e, got);
    `CHECK(got, 8'h00)
    cpu.set_index(8'h10);
    cpu.unlock_write(ctrl_val(1'b0, 1'b0, 1'b1), int'(KEY_GAP));
    cpu.rd_reg(ADDR_CONTROL, got);
    `CHECK(got & 8'hf7, 8'h00)
    repeat (WCYC + 4) cpu.step();
    `CHECK(writeDoneFlag, 1'b0)
    cpu.wr_reg(ADDR_CONTROL, ctrl_val(1'b0, 1'b1, 1'b0));
    // Corner and random locations, each written then read back
    for (int k = 0; k < 8; k++) begin
      a = (k < 4) ? corner[k] : 8'($urandom);
      d = 8'($urandom);
      codeProtect = 1'($urandom);
      start_write(a, d, int'(KEY_GAP));
      `CHECK(progAccessOk, !codeProtect)
      expMem[a] = d;
      wait_done(ctrl_val(1'b0, 1'b1, 1'b0));
      cpu.ee_read(a, ctrl_val(1'b0, 1'b1, 1'b0), got);
      `CHECK(got, expMem[a])
    end
    // Mistimed key sequences must not start a write
    for (int g = 1; g <= 3; g += 2) begin
      start_write(8'h21, 8'h5a, g);
      repeat (WCYC + 4) cpu.step();
      `CHECK(writeDoneFlag, 1'b0)
    end
    // Permit dropped and a second start while busy
    start_write(8'h33, 8'hc3, int'(KEY_GAP));
    cpu.wr_reg(ADDR_CONTROL, 8'h00);
    cpu.unlock_write(ctrl_val(1'b0, 1'b1, 1'b1), int'(KEY_GAP));
    cpu.wr_reg(ADDR_CONTROL, 8'h00);
    wait_done(8'h00);
    cpu.ee_read(8'h33, 8'h00, got);
    `CHECK(got, 8'hc3)
    cpu.ee_read(8'h80, 8'h00, got);
    `CHECK(got, expMem[8'h80])
    // Warm reset in mid-write
    cpu.wr_reg(ADDR_CONTROL, ctrl_val(1'b0, 1'b1, 1'b0));
    start_write(8'h44, 8'h96, int'(KEY_GAP));
    repeat (3) cpu.step();
    warmRst = 1'b1;
    cpu.step();
    warmRst = 1'b0;
    cpu.rd_reg(ADDR_CONTROL, got);
    `CHECK(got, ctrl_val(1'b1, 1'b0, 1'b0))
    cpu.rd_reg(ADDR_DATA_BYTE, got);
    `CHECK(got, 8'h96)
    cpu.rd_reg(ADDR_LOCATION, got);
    `CHECK(got, 8'h44)
    repeat (WCYC + 4) cpu.step();
    `CHECK(writeDoneFlag, 1'b0)
    // Retry with the abort flag still set; a clean finish clears it
    cpu.wr_reg(ADDR_CONTROL, ctrl_val(1'b1, 1'b1, 1'b0));
    cpu.unlock_write(ctrl_val(1'b1, 1'b1, 1'b1), int'(KEY_GAP));
    wait_done(ctrl_val(1'b0, 1'b1, 1'b0));
    cpu.ee_read(8'h44, ctrl_val(1'b0, 1'b1, 1'b0), got);
    `CHECK(got, 8'h96)
    // Small variant: top index bit kept clear, top location written and read back
    cpuSmall.wr_reg(ADDR_CONTROL, ctrl_val(1'b0, 1'b1, 1'b0));
    cpuSmall.set_index(8'hff);
    cpuSmall.wr_reg(ADDR_DATA_BYTE, 8'h3c);
    cpuSmall.unlock_write(ctrl_val(1'b0, 1'b1, 1'b1), int'(KEY_GAP));
    repeat (WCYC + 4) cpuSmall.step();
    `CHECK(writeDoneFlagS, 1'b1)
    `CHECK(progAccessOkS, !codeProtect)
    cpuSmall.ee_read(8'h7f, ctrl_val(1'b0, 1'b1, 1'b0), got);
    `CHECK(got, 8'h3c)
    cpuSmall.rd_reg(ADDR_LOCATION, got);
    `CHECK(got, 8'h7f)
    test_done();
  end

  initial begin
    repeat (4000) @(posedge clk);
    num_errors++;
    test_done();
  end
endmodule : tb_top
